//--- core/wwd_top.v
// Purpose: windowed watchdog timer with AXI4-Lite register access
// Assumes: all inputs synchronous to clk; configuration levels stable after reset
// Notes:   reset request and wake request are one-cycle pulses
`timescale 1ns/1ps
`include "wwd_map.vh"

// Function
// - clock source code 001 picks medium oscillator, 000 low oscillator; others reserved
// - opening fraction codes 111..000 give 100 down to 12.5 percent open
// - window opens when timer value reaches threshold, four steps per code
// - config clock 111 makes source field reset to 000 and writable
// - opening fraction resets from config, writable only when config is 111
// - 18-bit prescale count readable across low, high and timer registers
// - timer register bit 2 shows armed state
// - modes 1x enable oscillator by config; mode 01 by register field
// - mode 11 always active, software enable ignored
// - mode 10 active awake, disabled in sleep
// - mode 01 follows software enable; mode 00 always disabled
// - config prescale all ones lets register pick period, else config does
// - default period after reset is two seconds
// - clear outside open window is a violation causing reset
// - window size from config unless config is 111, then register
// - violation clears active-low violation flag; reset or firmware sets it
// - counter cleared on reset, valid clear, sleep entry, irq wake, disabled, startup
// - any write with byte 0 strobe set to either control register clears the counter
// - unarmed clear in windowed mode is a violation; reading control 0 arms
// - time-out in sleep wakes device instead of reset
// - time-out without clear generates a reset
// - prescale code 0 divides by 32, doubling to code 10010; above acts as 0
module wwd_top (
    input  wire        clk,
    input  wire        rstn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [1:0]  modeConfiguration,
    input  wire [2:0]  configClockSelection,
    input  wire [2:0]  configOpeningSelection,
    input  wire [4:0]  configPrescaleSelection,
    input  wire        sleepActive,
    input  wire        clearInstruction,
    input  wire        wakeByInterrupt,
    input  wire        oscillatorStartupTimer,
    output reg         resetRequest_r,
    output reg         wakeRequest_r,
    output reg         lowFreqOscEn_r,
    output reg         medFreqOscEn_r,
    output reg         timeoutResetFlagN_r,
    output reg         windowViolationFlagN_r
);
    // ********************
    // register fields and counters
    // ********************
    reg  [4:0]  prescaleSelect_r;
    reg         softwareEnable_r;
    reg  [2:0]  clockSourceSelect_r;
    reg  [2:0]  openingSelect_r;
    reg         cfgLoad_r;
    reg         armed_r;
    reg  [17:0] prescaleCount_r;
    reg  [4:0]  windowTimer_r;
    reg         sleepDly_r;
    reg  [4:0]  wrAddr_r;
    reg  [31:0] wrData_r;
    reg  [3:0]  wrStrb_r;
    reg         awHeld_r;
    reg         wHeld_r;
    wire        tick;

    // ********************
    // mode and selection decode
    // ********************
    // active per mode: always on, awake only, software enable, or off
    reg active;
    always @* begin
        case (modeConfiguration)
            `WWD_MODE_ALWAYS: active = 1'b1;
            `WWD_MODE_AWAKE:  active = ~sleepActive;
            `WWD_MODE_SOFT:   active = softwareEnable_r;
            default:          active = 1'b0;
        endcase
    end

    wire [2:0] srcSel = modeConfiguration[1] ? configClockSelection : clockSourceSelect_r;
    // reserved codes stop the time base
    wire lfWant = active & (srcSel == `WWD_CS_LF);
    wire mfWant = active & (srcSel == `WWD_CS_MF);

    // register prescale only when config is all ones
    wire [4:0] psCode = (configPrescaleSelection == `WWD_PS_SOFT) ? prescaleSelect_r
                                                                   : configPrescaleSelection;
    // reserved codes fall back to divide by 32
    wire [4:0] psEff = (psCode > `WWD_PS_MAX) ? 5'h0 : psCode;
    wire [18:0] psOne = 19'h1 << psEff;
    wire [17:0] psLast = psOne[17:0] - 18'h1;

    wire [2:0] winSel = (configOpeningSelection == `WWD_WIN_SOFT) ? openingSelect_r
                                                                   : configOpeningSelection;
    // threshold is four steps per code below 111
    wire [4:0] openAt = {~winSel, 2'b00};
    wire       windowOpen = (windowTimer_r >= openAt);
    wire       windowed = (winSel != `WWD_WIN_FULL);

    // ********************
    // clear instruction judgement
    // ********************
    // closed window clear is a violation
    // unarmed clear is a violation too when windowed
    wire clrValid = clearInstruction & active & (~windowed | (armed_r & windowOpen));
    wire violation = clearInstruction & active & windowed & ~(armed_r & windowOpen);

    wire psWrap = tick & (prescaleCount_r == psLast);
    wire timeout = active & psWrap & (windowTimer_r == `WWD_WT_LAST);

    // ********************
    // bus decode
    // ********************
    wire awFire = s_axi_awvalid & s_axi_awready;
    wire wFire  = s_axi_wvalid & s_axi_wready;
    wire arFire = s_axi_arvalid & s_axi_arready;
    wire wrDo   = awHeld_r & wHeld_r & ~s_axi_bvalid;
    wire wrLow  = wrDo & wrStrb_r[0];
    wire wrCtrl0 = wrLow & (wrAddr_r == `WWD_ADDR_CTRL0);
    wire wrCtrl1 = wrLow & (wrAddr_r == `WWD_ADDR_CTRL1);
    wire wrFlags = wrLow & (wrAddr_r == `WWD_ADDR_FLAGS);
    wire rdCtrl0 = arFire & (s_axi_araddr == `WWD_ADDR_CTRL0);

    // write or read address known to the map
    function mapped;
        input [4:0] a;
        begin
            mapped = (a == `WWD_ADDR_CTRL0) | (a == `WWD_ADDR_CTRL1) |
                     (a == `WWD_ADDR_PSLOW) | (a == `WWD_ADDR_PSHIGH) |
                     (a == `WWD_ADDR_TIMER) | (a == `WWD_ADDR_FLAGS);
        end
    endfunction

    wire sleepEnter = sleepActive & ~sleepDly_r;
    wire clrCnt = clrValid | sleepEnter | wakeByInterrupt | ~active |
                  oscillatorStartupTimer | wrCtrl0 | wrCtrl1 | timeout | violation;

    // ********************
    // time base
    // ********************
    wwd_tick_gen u_tick (
        .clk    (clk),
        .rstn   (rstn),
        .lfEn   (lfWant),
        .mfEn   (mfWant),
        .tick_r (tick)
    );

    // oscillator enables follow the chosen source
    always @(posedge clk) begin
        if (!rstn) begin
            lowFreqOscEn_r <= 1'b0;
            medFreqOscEn_r <= 1'b0;
        end else begin
            lowFreqOscEn_r <= lfWant;
            medFreqOscEn_r <= mfWant;
        end
    end

    // ********************
    // counters
    // ********************
    // prescaler steps the window timer
    always @(posedge clk) begin
        if (!rstn || clrCnt) begin
            prescaleCount_r <= 18'h0;
            windowTimer_r   <= 5'h0;
        end else if (psWrap) begin
            prescaleCount_r <= 18'h0;
            windowTimer_r   <= windowTimer_r + 5'h1;
        end else if (tick) begin
            prescaleCount_r <= prescaleCount_r + 18'h1;
        end
    end

    // sleep edge detect; unreset so a sleep held through reset is no new entry
    always @(posedge clk) begin
        sleepDly_r <= sleepActive;
    end

    // reading control 0 arms; any clear instruction spends it
    always @(posedge clk) begin
        if (!rstn)
            armed_r <= 1'b0;
        else if (clearInstruction)
            armed_r <= 1'b0;
        else if (rdCtrl0)
            armed_r <= 1'b1;
    end

    // ********************
    // outcome pulses and flags
    // ********************
    // sleep time-out wakes; awake time-out resets; violation resets
    always @(posedge clk) begin
        if (!rstn) begin
            resetRequest_r <= 1'b0;
            wakeRequest_r  <= 1'b0;
        end else begin
            resetRequest_r <= violation | (timeout & ~sleepActive);
            wakeRequest_r  <= timeout & sleepActive;
        end
    end

    // violation clears flag, hardware event wins over a firmware write
    always @(posedge clk) begin
        if (!rstn) begin
            windowViolationFlagN_r <= 1'b1;
            timeoutResetFlagN_r    <= 1'b1;
        end else begin
            if (violation)
                windowViolationFlagN_r <= 1'b0;
            else if (wrFlags)
                windowViolationFlagN_r <= wrData_r[`WWD_FL_WV_N];
            if (timeout)
                timeoutResetFlagN_r <= 1'b0;
            else if (wrFlags)
                timeoutResetFlagN_r <= wrData_r[`WWD_FL_TO_N];
        end
    end

    // ********************
    // control registers
    // ********************
    // fields load from configuration on the first edge after reset release
    always @(posedge clk) begin
        if (!rstn) begin
            cfgLoad_r           <= 1'b1;
            prescaleSelect_r    <= 5'h0;
            softwareEnable_r    <= 1'b0;
            clockSourceSelect_r <= 3'h0;
            openingSelect_r     <= 3'h0;
        end else if (cfgLoad_r) begin
            cfgLoad_r <= 1'b0;
            prescaleSelect_r <= (configPrescaleSelection == `WWD_PS_SOFT) ? `WWD_PS_DEFAULT
                                                                          : configPrescaleSelection;
            // soft clock select starts at low oscillator
            clockSourceSelect_r <= (configClockSelection == `WWD_CS_SOFT) ? `WWD_CS_LF
                                                                          : configClockSelection;
            openingSelect_r <= configOpeningSelection;
        end else begin
            if (wrCtrl0) begin
                softwareEnable_r <= wrData_r[`WWD_C0_SEN];
                // prescale field writable only in soft mode
                if (configPrescaleSelection == `WWD_PS_SOFT)
                    prescaleSelect_r <= wrData_r[`WWD_C0_PS_HI:`WWD_C0_PS_LO];
            end
            if (wrCtrl1) begin
                // source field read-only unless config allows
                if (configClockSelection == `WWD_CS_SOFT)
                    clockSourceSelect_r <= wrData_r[`WWD_C1_CS_HI:`WWD_C1_CS_LO];
                if (configOpeningSelection == `WWD_WIN_SOFT)
                    openingSelect_r <= wrData_r[`WWD_C1_WIN_HI:`WWD_C1_WIN_LO];
            end
        end
    end

    // ********************
    // AXI4-Lite write channel
    // ********************
    // address and data are taken in either order; response follows both
    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `WWD_RESP_OKAY;
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            wrAddr_r      <= 5'h0;
            wrData_r      <= 32'h0;
            wrStrb_r      <= 4'h0;
        end else begin
            if (awFire) begin
                wrAddr_r      <= {s_axi_awaddr[4:2], 2'b00};
                awHeld_r      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (wFire) begin
                wrData_r     <= s_axi_wdata;
                wrStrb_r     <= s_axi_wstrb;
                wHeld_r      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wrDo) begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wrAddr_r) ? `WWD_RESP_OKAY : `WWD_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ********************
    // AXI4-Lite read channel
    // ********************
    // prescale count split over three registers; armed bit
    reg [31:0] rdMux;
    always @* begin
        rdMux = 32'h0;
        case ({s_axi_araddr[4:2], 2'b00})
            `WWD_ADDR_CTRL0:  rdMux[7:0] = {2'b00, prescaleSelect_r, softwareEnable_r};
            `WWD_ADDR_CTRL1:  rdMux[7:0] = {1'b0, clockSourceSelect_r, 1'b0, openingSelect_r};
            `WWD_ADDR_PSLOW:  rdMux[7:0] = prescaleCount_r[7:0];
            `WWD_ADDR_PSHIGH: rdMux[7:0] = prescaleCount_r[15:8];
            `WWD_ADDR_TIMER:  rdMux[7:0] = {windowTimer_r, armed_r, prescaleCount_r[17:16]};
            `WWD_ADDR_FLAGS:  rdMux[7:0] = {6'h0, windowViolationFlagN_r, timeoutResetFlagN_r};
            default:          rdMux = 32'h0;
        endcase
    end

    // one read at a time; data registered on the address handshake
    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `WWD_RESP_OKAY;
        end else if (arFire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdMux;
            s_axi_rresp   <= mapped({s_axi_araddr[4:2], 2'b00}) ? `WWD_RESP_OKAY
                                                                : `WWD_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // wwd_top

//--- core/wwd_map.vh
// Purpose: register map, field positions and timing constants of the windowed watchdog
// Assumes: 32-bit AXI4-Lite data, each register on an aligned word
// Notes:   definitions only
`ifndef WWD_MAP_VH
`define WWD_MAP_VH
// ****************************************************************
// register byte addresses
// ****************************************************************
`define WWD_ADDR_CTRL0      5'h00
`define WWD_ADDR_CTRL1      5'h04
`define WWD_ADDR_PSLOW      5'h08
`define WWD_ADDR_PSHIGH     5'h0c
`define WWD_ADDR_TIMER      5'h10
`define WWD_ADDR_FLAGS      5'h14
// ****************************************************************
// field positions
// ****************************************************************
`define WWD_C0_SEN          0
`define WWD_C0_PS_LO        1
`define WWD_C0_PS_HI        5
`define WWD_C1_WIN_LO       0
`define WWD_C1_WIN_HI       2
`define WWD_C1_CS_LO        4
`define WWD_C1_CS_HI        6
`define WWD_FL_TO_N         0
`define WWD_FL_WV_N         1
// ****************************************************************
// codes and reset values
// ****************************************************************
`define WWD_CS_LF           3'h0
`define WWD_CS_MF           3'h1
`define WWD_CS_SOFT         3'h7
`define WWD_WIN_SOFT        3'h7
`define WWD_WIN_FULL        3'h7
`define WWD_PS_SOFT         5'h1f
`define WWD_PS_DEFAULT      5'h0b
`define WWD_PS_MAX          5'h12
`define WWD_MODE_SOFT       2'h1
`define WWD_MODE_AWAKE      2'h2
`define WWD_MODE_ALWAYS     2'h3
`define WWD_WT_LAST         5'h1f
`define WWD_RESP_OKAY       2'h0
`define WWD_RESP_SLVERR     2'h2
// ****************************************************************
// time base
// ****************************************************************
`define WWD_CLK_HZ          20000000
`define WWD_LF_HZ           31000
`define WWD_MF_HZ           31250
`endif

//--- core/wwd_tick_gen.v
// Purpose: oscillator-rate tick enable for the watchdog time base
// Assumes: one system clock at the rate given in the map header
// Notes:   a reserved or disabled source yields no ticks
`timescale 1ns/1ps
`include "wwd_map.vh"

module wwd_tick_gen (
    input  wire       clk,
    input  wire       rstn,
    input  wire       lfEn,
    input  wire       mfEn,
    output reg        tick_r
);
    // ****************************************************************
    // divider
    // ****************************************************************
    localparam integer LF_DIV = `WWD_CLK_HZ / `WWD_LF_HZ;
    localparam integer MF_DIV = `WWD_CLK_HZ / `WWD_MF_HZ;
    localparam [9:0]   LF_LAST = LF_DIV[9:0] - 10'h1;
    localparam [9:0]   MF_LAST = MF_DIV[9:0] - 10'h1;

    reg  [9:0] divCnt_r;
    wire [9:0] divLast = mfEn ? MF_LAST : LF_LAST;
    wire       running = lfEn | mfEn;

    // count while a source runs; restart from zero when none does
    always @(posedge clk) begin
        if (!rstn || !running) begin
            divCnt_r <= 10'h0;
            tick_r   <= 1'b0;
        end else if (divCnt_r == divLast) begin
            divCnt_r <= 10'h0;
            tick_r   <= 1'b1;
        end else begin
            divCnt_r <= divCnt_r + 10'h1;
            tick_r   <= 1'b0;
        end
    end
endmodule // wwd_tick_gen

//--- verif/wwd_top_chk.sv
// Purpose: port-level checks of the windowed watchdog
// Assumes: configuration inputs held stable between resets
// Notes:   bound to the top module from the bench
`timescale 1ns/1ps
module wwd_top_chk (
    input logic        clk,
    input logic        rstn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_bvalid,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic [1:0]  modeConfiguration,
    input logic [2:0]  configClockSelection,
    input logic        sleepActive,
    input logic        resetRequest_r,
    input logic        wakeRequest_r,
    input logic        lowFreqOscEn_r,
    input logic        medFreqOscEn_r,
    input logic        timeoutResetFlagN_r,
    input logic        windowViolationFlagN_r
);
// ********************
// assertions
// ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // both oscillator requests dropped
    wire oscOff = !lowFreqOscEn_r && !medFreqOscEn_r;

    cause_flag_a: assert property (resetRequest_r |-> ##[0:1]
        (!timeoutResetFlagN_r || !windowViolationFlagN_r)) else $error("reset without cause");
    wake_sleep_a: assert property (wakeRequest_r |-> $past(sleepActive))
        else $error("wake request while awake");
    mode_off_a: assert property (modeConfiguration == 2'h0 |-> oscOff)
        else $error("oscillator on in off mode");
    sleep_off_a: assert property ((modeConfiguration == 2'h2 && sleepActive) [*2] |-> oscOff)
        else $error("oscillator on in sleep");
    low_src_a: assert property ((modeConfiguration[1] && !sleepActive
        && configClockSelection == 3'h0) [*3] |-> lowFreqOscEn_r && !medFreqOscEn_r)
        else $error("wrong oscillator chosen");
    read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h0) else $error("bad read answer");
    write_ans_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    to_flag_a: assert property ($fell(timeoutResetFlagN_r) |-> ##[0:2]
        (resetRequest_r || wakeRequest_r)) else $error("timeout flag without request");
    wv_flag_a: assert property ($fell(windowViolationFlagN_r) |-> ##[0:2] resetRequest_r)
        else $error("violation flag without reset");

    // main scenarios reached
    cover property (wakeRequest_r);
    cover property (resetRequest_r && !windowViolationFlagN_r);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // wwd_top_chk

//--- verif/wwd_cpu_model.sv
// Purpose: processor side issuing clear and wake pulses
// Assumes: one request from the bench gives one pulse
// Notes:   never pulses on its own
`timescale 1ns/1ps
module wwd_cpu_model (
    input  wire clk,
    input  wire doClear,
    input  wire doWake,
    output reg  clearInstruction,
    output reg  wakeByInterrupt
);
    initial clearInstruction = 1'b0;
    initial wakeByInterrupt = 1'b0;
    // clears only when the program asks
    always @(posedge clk) begin
        clearInstruction <= doClear;
        wakeByInterrupt <= doWake;
    end
endmodule // wwd_cpu_model

//--- verif/wwd_top_tb.sv
// Purpose: self-checking bench of the windowed watchdog
// Assumes: low oscillator tick every 645 clocks, prescale code 0
// Notes:   random write data come from a fixed seed
`timescale 1ns/1ps
module wwd_top_tb;
// ********************
// stimulus and wiring
// ********************
    localparam int TK = 645;
    reg         clk = 1'b0;
    reg         rstn = 1'b0;
    reg  [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'h0;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg  [1:0]  modeConfiguration = 2'h3;
    reg  [2:0]  configClockSelection = 3'h0, configOpeningSelection = 3'h6;
    reg  [4:0]  configPrescaleSelection = 5'h00;
    reg         sleepActive = 1'b0, oscillatorStartupTimer = 1'b0;
    reg         doClear = 1'b0, doWake = 1'b0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        clearInstruction, wakeByInterrupt, resetRequest_r, wakeRequest_r;
    wire        lowFreqOscEn_r, medFreqOscEn_r, timeoutResetFlagN_r, windowViolationFlagN_r;
    int         n_fail = 0, comparisons = 0, nRst = 0, nWake = 0, seed = 11073, j;
    reg  [7:0]  rd;
    reg  [1:0]  rsp;

    wwd_top u_wwd_top (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .modeConfiguration,
        .configClockSelection, .configOpeningSelection, .configPrescaleSelection,
        .sleepActive, .clearInstruction, .wakeByInterrupt, .oscillatorStartupTimer,
        .resetRequest_r, .wakeRequest_r, .lowFreqOscEn_r, .medFreqOscEn_r,
        .timeoutResetFlagN_r, .windowViolationFlagN_r);
    wwd_cpu_model u_wwd_cpu_model (.clk, .doClear, .doWake, .clearInstruction,
        .wakeByInterrupt);

    // 20 MHz clock
    always #25 clk = ~clk;
    // count one-cycle request pulses
    always @(posedge clk) begin
        if (resetRequest_r === 1'b1) nRst++;
        if (wakeRequest_r === 1'b1) nWake++;
    end
// ********************
// tasks
// ********************
    task complete_run;
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask
    // reset for six cycles with new configuration levels
    task cfg(input [1:0] m, input [2:0] c, input [2:0] w, input [4:0] p);
        @(posedge clk);
        rstn <= 1'b0;
        modeConfiguration <= m;
        configClockSelection <= c;
        configOpeningSelection <= w;
        configPrescaleSelection <= p;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // one write, address and data offered together
    task wr(input [4:0] a, input [7:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask
    // one read; the byte lands in rd, the response in rsp
    task rdr(input [4:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata[7:0];
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task rchk(input [4:0] a, input [7:0] exp);
        rdr(a);
        chk(rd, exp);
    endtask
    // one clear pulse, then let the request land
    task clr;
        @(posedge clk);
        doClear <= 1'b1;
        @(posedge clk);
        doClear <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
// ********************
// scenarios
// ********************
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        complete_run;
    end
    initial begin
        cfg(2'h3, 3'h0, 3'h6, 5'h00);
        rchk(5'h08, 8'h00);
        rchk(5'h0c, 8'h00);
        rchk(5'h10, 8'h00);
        rchk(5'h14, 8'h03);
        rchk(5'h18, 8'h00);
        chk(rsp, 2'h2);
        for (j = 0; j < 4; j++) begin
            wr(5'h04, 8'($random(seed)));
            rchk(5'h04, 8'h06);
        end
        // unarmed clear inside the open window
        repeat (5 * TK) @(posedge clk);
        clr;
        chk(nRst, 1);
        rchk(5'h14, 8'h01);
        wr(5'h14, 8'h03);
        chk(rsp, 2'h0);
        rchk(5'h14, 8'h03);
        // armed clear while the window is still shut
        rchk(5'h00, 8'h00);
        rdr(5'h10);
        chk(rd[2], 1'b1);
        clr;
        chk(nRst, 2);
        // armed clear inside the window is accepted
        repeat (5 * TK) @(posedge clk);
        rdr(5'h00);
        clr;
        chk(nRst, 2);
        rdr(5'h10);
        chk({rd[7:4], rd[2]}, 5'h00);
        repeat (3 * TK) @(posedge clk);
        rdr(5'h10);
        chk(rd[7:3] > 5'h01, 1'b1);
        @(posedge clk);
        doWake <= 1'b1;
        @(posedge clk);
        doWake <= 1'b0;
        rdr(5'h10);
        chk(rd[7:4], 4'h0);
        repeat (3 * TK) @(posedge clk);
        wr(5'h00, 8'h00);
        rdr(5'h10);
        chk(rd[7:4], 4'h0);
        oscillatorStartupTimer <= 1'b1;
        repeat (3 * TK) @(posedge clk);
        rchk(5'h10, 8'h00);
        oscillatorStartupTimer <= 1'b0;
        // time-out awake, then asleep
        cfg(2'h3, 3'h0, 3'h7, 5'h00);
        repeat (33 * TK) @(posedge clk);
        chk(nRst, 3);
        rchk(5'h14, 8'h02);
        sleepActive <= 1'b1;
        repeat (33 * TK) @(posedge clk);
        chk({nWake[1:0], nRst[1:0], lowFreqOscEn_r}, 5'b01111);
        sleepActive <= 1'b0;
        // software-controlled mode with register-chosen source
        cfg(2'h1, 3'h7, 3'h7, 5'h1f);
        chk({lowFreqOscEn_r, medFreqOscEn_r}, 2'b00);
        rchk(5'h00, 8'h16);
        rchk(5'h04, 8'h07);
        wr(5'h00, 8'h03);
        rchk(5'h00, 8'h03);
        chk({lowFreqOscEn_r, medFreqOscEn_r}, 2'b10);
        wr(5'h04, 8'h17);
        rchk(5'h04, 8'h17);
        chk({lowFreqOscEn_r, medFreqOscEn_r}, 2'b01);
        sleepActive <= 1'b1;
        repeat (3) @(posedge clk);
        chk({lowFreqOscEn_r, medFreqOscEn_r}, 2'b01);
        sleepActive <= 1'b0;
        wr(5'h00, 8'h00);
        repeat (2) @(posedge clk);
        chk({lowFreqOscEn_r, medFreqOscEn_r}, 2'b00);
        // off in sleep, then always off
        cfg(2'h2, 3'h0, 3'h7, 5'h00);
        chk({lowFreqOscEn_r, medFreqOscEn_r}, 2'b10);
        sleepActive <= 1'b1;
        repeat (3) @(posedge clk);
        chk({lowFreqOscEn_r, medFreqOscEn_r}, 2'b00);
        sleepActive <= 1'b0;
        cfg(2'h0, 3'h0, 3'h7, 5'h00);
        chk({lowFreqOscEn_r, medFreqOscEn_r}, 2'b00);
        complete_run;
    end
endmodule // wwd_top_tb

bind wwd_top wwd_top_chk u_wwd_top_chk (.clk, .rstn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .s_axi_rresp, .modeConfiguration, .configClockSelection, .sleepActive,
    .resetRequest_r, .wakeRequest_r, .lowFreqOscEn_r, .medFreqOscEn_r,
    .timeoutResetFlagN_r, .windowViolationFlagN_r);
